// File: rtl/pwrloss_seq.sv
// Power-loss stop sequencer: top with APB registers and drive-side ports.
// Assumes power pins are asynchronous; drive-core inputs share pclk.
`timescale 1ns/1ps
`default_nettype none
module pwrloss_seq import pwrloss_pkg::*; #(
	parameter int CYCLES_PER_MS = CYC_PER_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_r,
	output logic pready_r,
	output logic pslverr_r,
	input wire logic main_power_on,
	input wire logic pn_undervoltage,
	input wire logic [15:0] actual_speed,
	input wire logic servo_off_busy,
	input wire logic [2:0] pds_state,
	output logic decel_active_r,
	output logic [2:0] decel_src_r,
	output logic [3:0] decel_code_r,
	output logic [2:0] pds_req_r,
	output logic voltage_enabled_r,
	output logic [2:0] alarm_r
);
	pwrloss_cfg_if cfg();
	logic tick;
	logic pwr_s1_r, pwr_s2_r, uv_s1_r, uv_s2_r;
	seq_t state_r;
	logic [10:0] ms_cnt_r;
	pds_t pds_off_r;
	logic so_r, uv_seen_r;
	logic stopped, late_due, sequencing, bit0, code_zero;
	src_t src;
	logic [3:0] code;
	pds_t pds_dur, pds_aft;
	logic ac_raise, abort_now, abort_after;
	logic [2:0] alarm_set;

	pwrloss_regs u_regs (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata_r(prdata_r), .pready_r(pready_r), .pslverr_r(pslverr_r),
		.cfg(cfg.regs)
	);
	ms_tick #(.CYCLES(CYCLES_PER_MS)) u_tick (
		.pclk(pclk), .presetn(presetn), .tick_r(tick)
	);

	// ==================================================
	// Pin synchronisers.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Reset to the powered level, so that release is not a loss.
			pwr_s1_r <= 1'b1;
			pwr_s2_r <= 1'b1;
			uv_s1_r <= 1'b0;
			uv_s2_r <= 1'b0;
		end else begin
			pwr_s1_r <= main_power_on;
			pwr_s2_r <= pwr_s1_r;
			uv_s1_r <= pn_undervoltage;
			uv_s2_r <= uv_s1_r;
		end
	end

	assign stopped = actual_speed <= STOP_SPEED_RPM;
	assign late_due = cfg.power_off_detect_time != DETECT_MAX_MS &&
		ms_cnt_r >= cfg.power_off_detect_time;
	assign sequencing = state_r == ST_EARLY || state_r == ST_LATE;
	assign bit0 = cfg.undervoltage_trip_select[0];

	// ==================================================
	// Deceleration and PDS choice for the current phase.
	always_comb begin
		src = SRC_NONE;
		code = 4'h0;
		pds_dur = pds_off_r;
		pds_aft = pds_off_r;
		ac_raise = 1'b0;
		abort_now = 1'b0;
		abort_after = 1'b0;
		code_zero = 1'b0;
		unique case (cfg.abort_option)
			2'd0: begin
				if (state_r == ST_LATE && bit0) begin
					src = SRC_ALARM;
					ac_raise = 1'b1;
					pds_dur = PDS_FRA;
					pds_aft = PDS_FAULT;
				end else if (state_r == ST_LATE) begin
					src = SRC_POWER_OFF;
					pds_aft = pds_off_r == PDS_OP_EN ? PDS_RTSO : PDS_SOD;
				end else begin
					pds_aft = pds_off_r == PDS_QS_ACTIVE ? PDS_SOD : pds_off_r;
				end
			end
			2'd1: begin
				code_zero = cfg.fault_reaction_code == 4'h0;
				pds_dur = PDS_FRA;
				pds_aft = PDS_FAULT;
				abort_now = code_zero;
				abort_after = !code_zero;
				src = code_zero ? SRC_ALARM : SRC_FAULT_CODE;
				if (state_r == ST_LATE && !code_zero) begin
					src = bit0 ? SRC_ALARM : SRC_POWER_OFF;
					ac_raise = bit0;
				end
			end
			default: begin
				code_zero = cfg.abort_option == 2'd2 ?
					cfg.shutdown_code == 4'h0 : cfg.quick_stop_code == 4'h0;
				pds_dur = cfg.abort_option == 2'd2 ? pds_off_r : PDS_QS_ACTIVE;
				pds_aft = PDS_SOD;
				if (state_r != ST_LATE)
					src = code_zero ? SRC_SERVO_OFF :
						cfg.abort_option == 2'd2 ? SRC_SHUTDOWN : SRC_QUICK_STOP;
				else if (code_zero || !bit0)
					src = SRC_POWER_OFF;
				else begin
					src = SRC_ALARM;
					ac_raise = 1'b1;
					pds_dur = PDS_FRA;
					pds_aft = PDS_FAULT;
				end
			end
		endcase
		if (so_r && state_r != ST_LATE) begin
			src = SRC_SERVO_OFF;
			pds_aft = PDS_RTSO;
		end
		if (uv_seen_r) begin
			src = SRC_ALARM;
			pds_dur = PDS_FRA;
			pds_aft = PDS_FAULT;
		end
		unique case (src)
			SRC_SERVO_OFF: code = cfg.servo_off_sequence_select;
			SRC_POWER_OFF: code = cfg.power_off_sequence_select;
			SRC_ALARM: code = cfg.alarm_sequence_select;
			SRC_FAULT_CODE: code = cfg.fault_reaction_code;
			SRC_SHUTDOWN: code = cfg.shutdown_code;
			SRC_QUICK_STOP: code = cfg.quick_stop_code;
			default: code = 4'h0;
		endcase
	end

	// ==================================================
	// Sequence state and elapsed-time counter.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			ms_cnt_r <= 11'h0;
			pds_off_r <= PDS_NOT_READY;
			so_r <= 1'b0;
			uv_seen_r <= 1'b0;
		end else begin
			if (state_r == ST_IDLE)
				ms_cnt_r <= 11'h0;
			else if (tick && ms_cnt_r != DETECT_MAX_MS)
				ms_cnt_r <= ms_cnt_r + 11'h1;
			if (uv_s2_r && !uv_seen_r && state_r != ST_STOPPED) begin
				uv_seen_r <= 1'b1;
				state_r <= ST_LATE;
				if (state_r == ST_IDLE)
					pds_off_r <= pds_t'(pds_state);
			end else begin
				unique case (state_r)
					ST_IDLE: if (!pwr_s2_r) begin
						state_r <= ST_HOLD;
						pds_off_r <= pds_t'(pds_state);
						so_r <= servo_off_busy;
					end
					ST_HOLD: if (pwr_s2_r)
						state_r <= ST_IDLE;
					else if (ms_cnt_r >= START_DELAY_MS)
						state_r <= ST_EARLY;
					ST_EARLY: if (stopped)
						state_r <= ST_STOPPED;
					else if (late_due)
						state_r <= ST_LATE;
					ST_LATE: if (stopped)
						state_r <= ST_STOPPED;
					ST_STOPPED: if (pwr_s2_r && !uv_s2_r) begin
						state_r <= ST_IDLE;
						so_r <= 1'b0;
						uv_seen_r <= 1'b0;
					end
					default: state_r <= ST_IDLE;
				endcase
			end
		end
	end

	// ==================================================
	// Drive-side outputs.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			decel_active_r <= 1'b0;
			decel_src_r <= SRC_NONE;
			decel_code_r <= 4'h0;
			pds_req_r <= PDS_NOT_READY;
			voltage_enabled_r <= 1'b0;
		end else begin
			voltage_enabled_r <= pwr_s2_r;
			decel_active_r <= sequencing && src != SRC_NONE && !stopped;
			decel_src_r <= sequencing ? src : SRC_NONE;
			decel_code_r <= sequencing ? code : 4'h0;
			if (sequencing && stopped)
				pds_req_r <= pds_aft;
			else if (sequencing)
				pds_req_r <= pds_dur;
			else if (state_r != ST_STOPPED)
				pds_req_r <= pds_state;
		end
	end

	// Sticky alarms; a set in the clearing cycle wins.
	assign alarm_set[AL_PN] = uv_s2_r;
	assign alarm_set[AL_AC] = state_r == ST_LATE && ac_raise && !uv_seen_r;
	assign alarm_set[AL_ABORT] = sequencing && (abort_now ||
		(abort_after && stopped));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			alarm_r <= 3'h0;
		else
			alarm_r <= alarm_set | (alarm_r & ~cfg.alarm_clr);
	end

	always_comb begin
		cfg.status_word = 32'h0;
		cfg.status_word[ST_VOLT_BIT] = voltage_enabled_r;
		cfg.status_word[ST_STATE_LSB+:3] = state_r;
		cfg.status_word[ST_PDS_LSB+:3] = pds_req_r;
		cfg.status_word[ST_DECEL_BIT] = decel_active_r;
		cfg.status_word[AL_ABORT:AL_PN] = alarm_r;
	end

	// ==================================================
	// Checks.
	sequence s_uv_rise;
		$rose(uv_s2_r) && state_r != ST_STOPPED;
	endsequence
	sequence s_alarm_decel;
		##[1:3] (decel_src_r == SRC_ALARM && alarm_r[AL_PN]);
	endsequence
	chk_early_start_delay: assert property (@(posedge pclk) disable iff
		(!presetn) $rose(state_r == ST_EARLY) |-> ms_cnt_r >= START_DELAY_MS)
		else $error("Early deceleration before 70 ms.");
	chk_late_after_time: assert property (@(posedge pclk) disable iff
		(!presetn) $rose(state_r == ST_LATE) && !uv_seen_r |->
		ms_cnt_r >= cfg.power_off_detect_time)
		else $error("Late deceleration before detection time.");
	chk_stop_at_speed: assert property (@(posedge pclk) disable iff
		(!presetn) sequencing && stopped && !(uv_s2_r && !uv_seen_r) |=>
		state_r == ST_STOPPED)
		else $error("Stop not taken at low speed.");
	chk_no_late_after_stop: assert property (@(posedge pclk) disable iff
		(!presetn) state_r == ST_STOPPED |=> state_r != ST_LATE)
		else $error("Late deceleration after stop.");
	chk_2000_never_late: assert property (@(posedge pclk) disable iff
		(!presetn) cfg.power_off_detect_time == DETECT_MAX_MS && !uv_seen_r
		&& state_r == ST_EARLY |=> state_r != ST_LATE)
		else $error("Power-off deceleration with detection off.");
	chk_voltage_bit: assert property (@(posedge pclk) disable iff
		(!presetn) $rose(pwr_s2_r) |=> voltage_enabled_r &&
		cfg.status_word[ST_VOLT_BIT])
		else $error("Voltage enabled bit not raised.");
	chk_uv_priority: assert property (@(posedge pclk) disable iff
		(!presetn) s_uv_rise |-> s_alarm_decel)
		else $error("Undervoltage not handled first.");
	chk_detect_range: assert property (@(posedge pclk) disable iff
		(!presetn) cfg.power_off_detect_time >= DETECT_MIN_MS &&
		cfg.power_off_detect_time <= DETECT_MAX_MS)
		else $error("Detection time out of range.");
	chk_opt1_fault_end: assert property (@(posedge pclk) disable iff
		(!presetn) sequencing && stopped && cfg.abort_option == 2'd1 && !so_r
		|=> pds_req_r == PDS_FAULT)
		else $error("Fault option did not end in Fault.");
endmodule // pwrloss_seq
`default_nettype wire

// File: rtl/pwrloss_pkg.sv
// Constants, register map and types of the power-loss stop sequencer.
// Assumes a 125 MHz APB clock and a drive core sharing that clock.
package pwrloss_pkg;
	// ==================================================
	// Timing.
	localparam int CLK_PERIOD_NS = 8;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int CYC_PER_MS = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [10:0] START_DELAY_MS = 11'd70;
	localparam logic [10:0] DETECT_MIN_MS = 11'd70;
	localparam logic [10:0] DETECT_MAX_MS = 11'd2000;
	localparam logic [15:0] STOP_SPEED_RPM = 16'd30;
	// ==================================================
	// Register offsets.
	localparam logic [7:0] ABORT_CFG_OFS = 8'h00;
	localparam logic [7:0] OPTION_CODES_OFS = 8'h04;
	localparam logic [7:0] SEQ_SELECT_OFS = 8'h08;
	localparam logic [7:0] DETECT_TIME_OFS = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;
	localparam logic [7:0] ALARMS_OFS = 8'h14;
	// ==================================================
	// Field positions.
	localparam int TRIP_LSB = 8;
	localparam int CODE_B_LSB = 4;
	localparam int CODE_C_LSB = 8;
	localparam int ST_VOLT_BIT = 4;
	localparam int ST_STATE_LSB = 8;
	localparam int ST_PDS_LSB = 16;
	localparam int ST_DECEL_BIT = 24;
	localparam int AL_PN = 0;
	localparam int AL_AC = 1;
	localparam int AL_ABORT = 2;
	// ==================================================
	// Types.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_HOLD = 3'b001, ST_EARLY = 3'b011,
		ST_LATE = 3'b010, ST_STOPPED = 3'b110
	} seq_t;
	typedef enum logic [2:0] {
		PDS_NOT_READY = 3'h0, PDS_SOD = 3'h1, PDS_RTSO = 3'h2,
		PDS_SWITCHED_ON = 3'h3, PDS_OP_EN = 3'h4, PDS_QS_ACTIVE = 3'h5,
		PDS_FRA = 3'h6, PDS_FAULT = 3'h7
	} pds_t;
	typedef enum logic [2:0] {
		SRC_NONE = 3'h0, SRC_SERVO_OFF = 3'h1, SRC_POWER_OFF = 3'h2,
		SRC_ALARM = 3'h3, SRC_FAULT_CODE = 3'h4, SRC_SHUTDOWN = 3'h5,
		SRC_QUICK_STOP = 3'h6
	} src_t;
endpackage

// File: rtl/pwrloss_cfg_if.sv
// Carrier between the register slave and the sequencer core.
// Assumes both ends run on the same pclk.
`timescale 1ns/1ps
`default_nettype none
interface pwrloss_cfg_if;
	import pwrloss_pkg::*;
	logic [1:0] abort_option;
	logic [1:0] undervoltage_trip_select;
	logic [3:0] fault_reaction_code;
	logic [3:0] shutdown_code;
	logic [3:0] quick_stop_code;
	logic [3:0] servo_off_sequence_select;
	logic [3:0] power_off_sequence_select;
	logic [3:0] alarm_sequence_select;
	logic [10:0] power_off_detect_time;
	logic [2:0] alarm_clr;
	logic [31:0] status_word;
	modport regs(output abort_option, undervoltage_trip_select,
		fault_reaction_code, shutdown_code, quick_stop_code,
		servo_off_sequence_select, power_off_sequence_select,
		alarm_sequence_select, power_off_detect_time, alarm_clr,
		input status_word);
	modport core(input abort_option, undervoltage_trip_select,
		fault_reaction_code, shutdown_code, quick_stop_code,
		servo_off_sequence_select, power_off_sequence_select,
		alarm_sequence_select, power_off_detect_time, alarm_clr,
		output status_word);
endinterface // pwrloss_cfg_if
`default_nettype wire

// File: rtl/ms_tick.sv
// Millisecond time base: one-cycle enable pulse every CYCLES clocks (CYC_PER_MS by default).
// Assumes a single free-running pclk.
`timescale 1ns/1ps
`default_nettype none
module ms_tick import pwrloss_pkg::*; #(
	parameter int CYCLES = CYC_PER_MS
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick_r
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);
	logic [W-1:0] cnt_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= '0;
			tick_r <= 1'b0;
		end else begin
			tick_r <= (cnt_r == LAST);
			cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
		end
	end
endmodule // ms_tick
`default_nettype wire

// File: rtl/pwrloss_regs.sv
// APB register slave of the power-loss stop sequencer.
// Assumes APB3 signalling; every access takes one wait state.
`timescale 1ns/1ps
`default_nettype none
module pwrloss_regs import pwrloss_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata_r,
	output logic pready_r,
	output logic pslverr_r,
	pwrloss_cfg_if.regs cfg
);
	logic acc;
	logic wr;
	logic hit;
	logic [10:0] dt;
	assign acc = psel & penable & ~pready_r;
	// Writes land at the edge that completes the transfer, with pready high.
	assign wr = psel & penable & pready_r & pwrite;
	assign dt = pwdata[10:0];
	always_comb begin
		unique case (paddr)
			ABORT_CFG_OFS, OPTION_CODES_OFS, SEQ_SELECT_OFS,
			DETECT_TIME_OFS, STATUS_OFS, ALARMS_OFS: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end

	// ==================================================
	// Bus handshake and read data.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0;
		end else begin
			pready_r <= acc;
			pslverr_r <= acc & ~hit;
			prdata_r <= 32'h0;
			if (acc && !pwrite) begin
				unique case (paddr)
					ABORT_CFG_OFS: prdata_r <= {22'h0,
						cfg.undervoltage_trip_select, 6'h0, cfg.abort_option};
					OPTION_CODES_OFS: prdata_r <= {20'h0, cfg.quick_stop_code,
						cfg.shutdown_code, cfg.fault_reaction_code};
					SEQ_SELECT_OFS: prdata_r <= {20'h0,
						cfg.alarm_sequence_select, cfg.power_off_sequence_select,
						cfg.servo_off_sequence_select};
					DETECT_TIME_OFS: prdata_r <= {21'h0,
						cfg.power_off_detect_time};
					STATUS_OFS, ALARMS_OFS: prdata_r <= cfg.status_word;
					default: prdata_r <= 32'h0;
				endcase
			end
		end
	end

	// ==================================================
	// Configuration; the detection time is held inside its legal range.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg.abort_option <= 2'h0;
			cfg.undervoltage_trip_select <= 2'h0;
			cfg.fault_reaction_code <= 4'h0;
			cfg.shutdown_code <= 4'h0;
			cfg.quick_stop_code <= 4'h0;
			cfg.servo_off_sequence_select <= 4'h0;
			cfg.power_off_sequence_select <= 4'h0;
			cfg.alarm_sequence_select <= 4'h0;
			cfg.power_off_detect_time <= DETECT_MAX_MS;
		end else if (wr) begin
			unique case (paddr)
				ABORT_CFG_OFS: begin
					cfg.abort_option <= pwdata[1:0];
					cfg.undervoltage_trip_select <= pwdata[TRIP_LSB+:2];
				end
				OPTION_CODES_OFS: begin
					cfg.fault_reaction_code <= pwdata[3:0];
					cfg.shutdown_code <= pwdata[CODE_B_LSB+:4];
					cfg.quick_stop_code <= pwdata[CODE_C_LSB+:4];
				end
				SEQ_SELECT_OFS: begin
					cfg.servo_off_sequence_select <= pwdata[3:0];
					cfg.power_off_sequence_select <= pwdata[CODE_B_LSB+:4];
					cfg.alarm_sequence_select <= pwdata[CODE_C_LSB+:4];
				end
				DETECT_TIME_OFS: begin
					if (pwdata[31:11] != 21'h0 || dt > DETECT_MAX_MS)
						cfg.power_off_detect_time <= DETECT_MAX_MS;
					else if (dt < DETECT_MIN_MS)
						cfg.power_off_detect_time <= DETECT_MIN_MS;
					else
						cfg.power_off_detect_time <= dt;
				end
				default: ;
			endcase
		end
	end

	// Alarm clear strobes, write one to clear.
	assign cfg.alarm_clr = (wr && paddr == ALARMS_OFS) ? pwdata[2:0] : 3'h0;
endmodule // pwrloss_regs
`default_nettype wire

// File: testbench/drive_model.sv
// Drive-side partner: a motor whose speed ramps down while decel is asked.
// Assumes the bench loads a start speed and PDS state before each loss.
`timescale 1ns/1ps
`default_nettype none
module drive_model import pwrloss_pkg::*; #(
	parameter logic [15:0] STEP = 16'h000A
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic [15:0] load_speed,
	input wire logic [2:0] load_pds,
	input wire logic decel_active_r,
	output logic [15:0] actual_speed,
	output logic [2:0] pds_state
);
	// ==================================================
	// Motor.
	// A smaller STEP gives a slow stop, a larger one a prompt stop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			actual_speed <= 16'h0000;
			pds_state <= PDS_SOD;
		end else if (load) begin
			actual_speed <= load_speed;
			pds_state <= load_pds;
		end else if (decel_active_r) begin
			if (actual_speed > STEP) begin
				actual_speed <= actual_speed - STEP;
			end else begin
				actual_speed <= 16'h0000;
			end
		end
	end
endmodule // drive_model
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench of the power-loss stop sequencer.
// Assumes APB access and the drive model as the motor side.
`timescale 1ns/1ps
`default_nettype none
module tb_top import pwrloss_pkg::*; ;
	// ==================================================
	// Signals.
	logic pclk, presetn, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata_r;
	logic pready_r, pslverr_r, main_power_on, pn_undervoltage;
	logic servo_off_busy, load, decel_active_r, voltage_enabled_r;
	logic [15:0] actual_speed, load_speed;
	logic [2:0] pds_state, load_pds, decel_src_r, pds_req_r, alarm_r;
	logic [3:0] decel_code_r;
	logic [31:0] r;
	logic e;
	int error_cnt = 0;
	int checks_done = 0;
	// ==================================================
	// Instances.
	// Ten cycles per millisecond keeps each loss between about 1100 and 1450 cycles.
	pwrloss_seq #(.CYCLES_PER_MS(10)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata_r(prdata_r), .pready_r(pready_r),
		.pslverr_r(pslverr_r), .main_power_on(main_power_on),
		.pn_undervoltage(pn_undervoltage), .actual_speed(actual_speed),
		.servo_off_busy(servo_off_busy), .pds_state(pds_state),
		.decel_active_r(decel_active_r), .decel_src_r(decel_src_r),
		.decel_code_r(decel_code_r), .pds_req_r(pds_req_r),
		.voltage_enabled_r(voltage_enabled_r), .alarm_r(alarm_r));
	drive_model motor (.pclk(pclk), .presetn(presetn), .load(load),
		.load_speed(load_speed), .load_pds(load_pds),
		.decel_active_r(decel_active_r), .actual_speed(actual_speed),
		.pds_state(pds_state));
	// ==================================================
	// Tasks.
	task results;
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		checks_done++;
		if (seen !== ex) begin
			error_cnt++;
			$display("[ERR] %s expected %0h seen %0h", nm, ex, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready_r !== 1'h1 && n < 20);
		if (n >= 20) begin
			error_cnt++;
			results();
		end
		r = prdata_r;
		e = pslverr_r;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(1'h0, a, 32'h0);
		chk(nm, r, ex);
	endtask
	task wait_stop;
		int n;
		n = 0;
		while (actual_speed > STOP_SPEED_RPM && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) begin
			error_cnt++;
			results();
		end
		cyc(2);
	endtask
	task loss(input logic [1:0] opt, input logic trip, input logic [31:0] codes,
		input logic [10:0] det, input logic busy, input int wt, input src_t es,
		input logic [3:0] ec, input pds_t ep, input logic [2:0] ea);
		apb(1'h1, ABORT_CFG_OFS, {23'h0, trip, 6'h0, opt});
		apb(1'h1, OPTION_CODES_OFS, codes);
		apb(1'h1, SEQ_SELECT_OFS, 32'h0000_0653);
		apb(1'h1, DETECT_TIME_OFS, {21'h0, det});
		load_speed <= 16'h03E8;
		load_pds <= PDS_OP_EN;
		load <= 1'h1;
		servo_off_busy <= busy;
		@(posedge pclk);
		load <= 1'h0;
		main_power_on <= 1'h0;
		cyc(wt - 30);
		chk("decel_before", 32'(decel_active_r), 32'h0);
		cyc(30);
		chk("decel_on", 32'(decel_active_r), 32'h1);
		chk("decel_src", 32'(decel_src_r), 32'(es));
		chk("decel_code", 32'(decel_code_r), 32'(ec));
		wait_stop();
		chk("pds_after", 32'(pds_req_r), 32'(ep));
		chk("alarms", 32'(alarm_r), 32'(ea));
		cyc(300);
		chk("no_late_decel", 32'(decel_active_r), 32'h0);
		main_power_on <= 1'h1;
		servo_off_busy <= 1'h0;
		cyc(5);
		chk("volt_en", 32'(voltage_enabled_r), 32'h1);
		apb(1'h0, STATUS_OFS, 32'h0);
		chk("status_volt", 32'(r[ST_VOLT_BIT]), 32'h1);
		apb(1'h1, ALARMS_OFS, 32'h0000_0007);
	endtask
	// ==================================================
	// Clock and watchdog.
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end
	initial begin
		#800000;
		error_cnt++;
		results();
	end
	// ==================================================
	// Sequence.
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		main_power_on = 1'h1;
		pn_undervoltage = 1'h0;
		servo_off_busy = 1'h0;
		load = 1'h0;
		load_speed = 16'h0000;
		load_pds = 3'h0;
		cyc(12);
		presetn <= 1'h1;
		rd("det_reset", DETECT_TIME_OFS, 32'h0000_07D0);
		rd("abort_reset", ABORT_CFG_OFS, 32'h0);
		apb(1'h1, DETECT_TIME_OFS, 32'h0000_0005);
		rd("det_low", DETECT_TIME_OFS, 32'h0000_0046);
		apb(1'h1, DETECT_TIME_OFS, 32'h0000_FFFF);
		rd("det_high", DETECT_TIME_OFS, 32'h0000_07D0);
		rd("unmapped_data", 8'h18, 32'h0);
		chk("unmapped_err", 32'(e), 32'h1);
		loss(2'h2, 1'h0, 32'h0, 11'h064, 1'h0, 720, SRC_SERVO_OFF, 4'h3,
			PDS_SOD, 3'h0);
		loss(2'h0, 1'h0, 32'h0, 11'h064, 1'h0, 1020, SRC_POWER_OFF, 4'h5,
			PDS_RTSO, 3'h0);
		loss(2'h0, 1'h1, 32'h0, 11'h064, 1'h0, 1020, SRC_ALARM, 4'h6,
			PDS_FAULT, 3'h2);
		loss(2'h1, 1'h0, 32'h4, 11'h7D0, 1'h0, 720, SRC_FAULT_CODE, 4'h4,
			PDS_FAULT, 3'h4);
		loss(2'h3, 1'h0, 32'h200, 11'h7D0, 1'h0, 720, SRC_QUICK_STOP, 4'h2,
			PDS_SOD, 3'h0);
		loss(2'h2, 1'h1, 32'h70, 11'h7D0, 1'h0, 720, SRC_SHUTDOWN, 4'h7,
			PDS_SOD, 3'h0);
		loss(2'h2, 1'h1, 32'h70, 11'h046, 1'h0, 720, SRC_ALARM, 4'h6,
			PDS_FAULT, 3'h2);
		loss(2'h1, 1'h0, 32'h0, 11'h7D0, 1'h0, 720, SRC_ALARM, 4'h6,
			PDS_FAULT, 3'h4);
		loss(2'h2, 1'h0, 32'h0, 11'h7D0, 1'h1, 720, SRC_SERVO_OFF, 4'h3,
			PDS_RTSO, 3'h0);
		load_speed <= 16'h03E8;
		load <= 1'h1;
		@(posedge pclk);
		load <= 1'h0;
		pn_undervoltage <= 1'h1;
		cyc(8);
		chk("uv_src", 32'(decel_src_r), 32'(SRC_ALARM));
		chk("uv_code", 32'(decel_code_r), 32'h6);
		chk("uv_alarm", 32'(alarm_r), 32'h1);
		pn_undervoltage <= 1'h0;
		wait_stop();
		cyc(5);
		apb(1'h1, ALARMS_OFS, 32'h0000_0007);
		cyc(2);
		chk("alarm_clear", 32'(alarm_r), 32'h0);
		presetn <= 1'h0;
		cyc(3);
		presetn <= 1'h1;
		rd("abort_rst2", ABORT_CFG_OFS, 32'h0);
		results();
	end
endmodule // tb_top
`default_nettype wire
